// ===== include/obc_pkg.sv
// Package: register map, field layout, reset values and encodings for the output bank control registers
// Behaviour
// - Each bank B output style bit selects the low-voltage differential driver at 0 and the emitter-coupled driver at 1, reset 0.
// - Each bank B output 2-bit swing field gives 350mV, 500mV, 750mV for 00, 01, 10; 11 is reserved; reset 00.
// - A written bank C divider ratio takes effect only after the clock-initialise bit toggles.
// - Address 0x20 holds the 6-bit bank C divider ratio in D5..D0 with D7..D6 reserved.
// - Address 0x22 holds bank C power-down at D7 and the setting source select at D0.
// - Addresses 0x24 and 0x25 each hold output power-down at D7, style at D2 and swing at D1..D0.
// - With source select 0 the bank C settings follow the bank control pins, with 1 the registers; the code takes only the divider from the pins.
// - Each bank C output style bit selects the low-voltage differential driver at 0 and the emitter-coupled driver at 1.
// - Each bank C output swing field decodes 00, 01, 10 to 350mV, 500mV, 750mV; 11 is reserved.
package obc_pkg;

  // ****************************************
  // Addresses
  // ****************************************
  localparam logic [7:0] ADDR_DIV   = 8'h20;
  localparam logic [7:0] ADDR_RSV_A = 8'h21;
  localparam logic [7:0] ADDR_PD    = 8'h22;
  localparam logic [7:0] ADDR_RSV_B = 8'h23;
  localparam logic [7:0] ADDR_OUT0  = 8'h24;
  localparam logic [7:0] ADDR_OUT1  = 8'h25;
  localparam logic [7:0] ADDR_RSV_C = 8'h26;
  localparam logic [7:0] ADDR_RSV_D = 8'h27;

  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int DIV_W     = 6;
  localparam int DIV_LSB   = 0;
  localparam int BANK_PD_B = 7;
  localparam int SRC_SEL_B = 0;
  localparam int OUT_PD_B  = 7;
  localparam int STYLE_B   = 2;
  localparam int SWING_LSB = 0;
  localparam int SWING_W   = 2;
  localparam int NUM_OUT   = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [5:0] DIV_RST   = 6'h0D;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic       STYLE_LVD = 1'b0;
  localparam logic       STYLE_ECD = 1'b1;
  localparam logic [1:0] SWING_350 = 2'h0;
  localparam logic [1:0] SWING_500 = 2'h1;
  localparam logic [1:0] SWING_750 = 2'h2;
  localparam logic [1:0] SWING_RSV = 2'h3;
  localparam logic [5:0] DIV_RSV   = 6'h00;
  localparam logic [7:0] OUT_MASK  = 8'h87;

  // Pin-mode divider table for bank control pin codes 01, 10 and 11
  localparam logic [5:0] PIN_DIV_01 = 6'h01;
  localparam logic [5:0] PIN_DIV_10 = 6'h02;
  localparam logic [5:0] PIN_DIV_11 = 6'h04;

  // Per-output swing as one-hot level select: bit0 350mV, bit1 500mV, bit2 750mV
  localparam logic [2:0] LVL_350 = 3'h1;
  localparam logic [2:0] LVL_500 = 3'h2;
  localparam logic [2:0] LVL_750 = 3'h4;
  localparam logic [2:0] LVL_OFF = 3'h0;

endpackage

// ===== rtl/obc_out_cfg.sv
// Per-output driver decode: style and swing to driver enables
`timescale 1ns/100ps
module obc_out_cfg (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       pd,
  input  wire logic       style,
  input  wire logic [1:0] swing,
  output logic            drv_en,
  output logic            drv_ecd,
  output logic [2:0]      drv_level
);

  logic       en_d;
  logic       en_q;
  logic       ecd_d;
  logic       ecd_q;
  logic [2:0] lvl_d;
  logic [2:0] lvl_q;

  always_comb begin
    en_d  = ~pd;
    ecd_d = (style == obc_pkg::STYLE_ECD);
    unique case (swing)
      obc_pkg::SWING_350: lvl_d = obc_pkg::LVL_350;
      obc_pkg::SWING_500: lvl_d = obc_pkg::LVL_500;
      obc_pkg::SWING_750: lvl_d = obc_pkg::LVL_750;
      obc_pkg::SWING_RSV: lvl_d = obc_pkg::LVL_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      en_q  <= 1'b0;
      ecd_q <= 1'b0;
      lvl_q <= obc_pkg::LVL_350;
    end else if (ce) begin
      en_q  <= en_d;
      ecd_q <= ecd_d;
      lvl_q <= lvl_d;
    end
  end

  assign drv_en    = en_q;
  assign drv_ecd   = ecd_q;
  assign drv_level = lvl_q;

endmodule

// ===== rtl/obc_regs.sv
// Output bank control register file with bank B and bank C driver settings
`timescale 1ns/100ps
module obc_regs #(
  parameter int NUM_B = 2
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  input  wire logic [7:0]           addr,
  input  wire logic [7:0]           wdata,
  output logic      [7:0]           rdata,
  input  wire logic                 init_clk,
  input  wire logic [1:0]           bank_c_pin_sel,
  input  wire logic [NUM_B-1:0]     bank_b_output_driver_style,
  input  wire logic [2*NUM_B-1:0]   bank_b_output_swing,
  output logic      [NUM_B-1:0]     bank_b_drv_en_ecd,
  output logic      [3*NUM_B-1:0]   bank_b_drv_level,
  output logic      [5:0]           bank_c_active_divider,
  output logic                      bank_c_bank_off,
  output logic      [1:0]           bank_c_drv_en,
  output logic      [1:0]           bank_c_drv_ecd,
  output logic      [5:0]           bank_c_drv_level
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [5:0] div_q;
  logic [5:0] div_d;
  logic       bank_pd_q;
  logic       bank_pd_d;
  logic       src_sel_q;
  logic       src_sel_d;
  logic [7:0] out_q [obc_pkg::NUM_OUT];
  logic [7:0] out_d [obc_pkg::NUM_OUT];
  logic [5:0] act_div_q;
  logic [5:0] act_div_d;
  logic       init_q;
  logic       init_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       bank_off_q;
  logic       bank_off_d;

  // Pin-mode divider decoded from the two bank control pins
  logic [5:0] pin_div;

  // Pin code 00 keeps the reset ratio so an unstrapped bank starts at the default
  always_comb begin
    unique case (bank_c_pin_sel)
      2'h0:    pin_div = obc_pkg::DIV_RST;
      2'h1:    pin_div = obc_pkg::PIN_DIV_01;
      2'h2:    pin_div = obc_pkg::PIN_DIV_10;
      2'h3:    pin_div = obc_pkg::PIN_DIV_11;
    endcase
  end

  always_comb begin
    div_d     = div_q;
    bank_pd_d = bank_pd_q;
    src_sel_d = src_sel_q;
    out_d     = out_q;
    rdata_d   = rdata_q;
    init_d    = init_clk;
    act_div_d = act_div_q;
    if (wr_en) begin
      unique case (addr)
        obc_pkg::ADDR_DIV: div_d = wdata[obc_pkg::DIV_LSB +: obc_pkg::DIV_W];
        obc_pkg::ADDR_PD: begin
          bank_pd_d = wdata[obc_pkg::BANK_PD_B];
          src_sel_d = wdata[obc_pkg::SRC_SEL_B];
        end
        obc_pkg::ADDR_OUT0: out_d[0] = wdata & obc_pkg::OUT_MASK;
        obc_pkg::ADDR_OUT1: out_d[1] = wdata & obc_pkg::OUT_MASK;
        default: ;
      endcase
    end
    // Reserved reads return zero so the host never sees stale bits
    if (rd_en) begin
      unique case (addr)
        obc_pkg::ADDR_DIV:  rdata_d = {2'h0, div_q};
        obc_pkg::ADDR_PD:   rdata_d = {bank_pd_q, 6'h00, src_sel_q};
        obc_pkg::ADDR_OUT0: rdata_d = out_q[0];
        obc_pkg::ADDR_OUT1: rdata_d = out_q[1];
        default:            rdata_d = obc_pkg::ZERO_BYTE;
      endcase
    end
    // Divider is committed on either edge of the initialise bit, never on write
    if (init_clk != init_q) begin
      act_div_d = src_sel_q ? div_q : pin_div;
    end
    bank_off_d = src_sel_q & bank_pd_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q      <= obc_pkg::DIV_RST;
      bank_pd_q  <= 1'b0;
      src_sel_q  <= 1'b0;
      out_q      <= '{default: obc_pkg::ZERO_BYTE};
      act_div_q  <= obc_pkg::DIV_RST;
      init_q     <= 1'b0;
      rdata_q    <= obc_pkg::ZERO_BYTE;
      bank_off_q <= 1'b0;
    end else if (ce) begin
      div_q      <= div_d;
      bank_pd_q  <= bank_pd_d;
      src_sel_q  <= src_sel_d;
      out_q      <= out_d;
      act_div_q  <= act_div_d;
      init_q     <= init_d;
      rdata_q    <= rdata_d;
      bank_off_q <= bank_off_d;
    end
  end

  assign rdata                 = rdata_q;
  assign bank_c_active_divider = act_div_q;
  assign bank_c_bank_off       = bank_off_q;

  // ****************************************
  // Bank C output drivers
  // ****************************************
  for (genvar i = 0; i < obc_pkg::NUM_OUT; i++) begin : g_c_out
    logic       c_pd;
    logic       c_sty;
    logic [1:0] c_swg;
    // Pin mode runs outputs enabled, default style and swing
    // Bank power-down overrides each output's own bit in register mode
    assign c_pd  = src_sel_q ? (out_q[i][obc_pkg::OUT_PD_B] | bank_pd_q) : 1'b0;
    assign c_sty = src_sel_q ? out_q[i][obc_pkg::STYLE_B] : obc_pkg::STYLE_LVD;
    assign c_swg = src_sel_q ? out_q[i][obc_pkg::SWING_LSB +: obc_pkg::SWING_W] : obc_pkg::SWING_350;
    obc_out_cfg u_c_cfg (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .pd        (c_pd),
      .style     (c_sty),
      .swing     (c_swg),
      .drv_en    (bank_c_drv_en[i]),
      .drv_ecd   (bank_c_drv_ecd[i]),
      .drv_level (bank_c_drv_level[3*i +: 3])
    );
  end

  // ****************************************
  // Bank B output drivers
  // ****************************************
  for (genvar j = 0; j < NUM_B; j++) begin : g_b_out
    obc_out_cfg u_b_cfg (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .pd        (1'b0),
      .style     (bank_b_output_driver_style[j]),
      .swing     (bank_b_output_swing[2*j +: 2]),
      .drv_en    (),
      .drv_ecd   (bank_b_drv_en_ecd[j]),
      .drv_level (bank_b_drv_level[3*j +: 3])
    );
  end

  // ****************************************
  // Checks
  // ****************************************
  a_div_hold_no_init: assert property (@(posedge clk) disable iff (rst)
    (ce && init_clk == init_q) |=> $stable(act_div_q))
    else $error("active divider changed without init toggle");
  a_div_commit: assert property (@(posedge clk) disable iff (rst)
    (ce && init_clk != init_q && src_sel_q) |=> (act_div_q == $past(div_q)))
    else $error("active divider not committed on init toggle");
  a_div_field_write: assert property (@(posedge clk) disable iff (rst)
    (ce && wr_en && addr == obc_pkg::ADDR_DIV) |=> (div_q == $past(wdata[obc_pkg::DIV_LSB +: obc_pkg::DIV_W])))
    else $error("divider field not stored");
  a_pd_src_write: assert property (@(posedge clk) disable iff (rst)
    (ce && wr_en && addr == obc_pkg::ADDR_PD) |=>
      (bank_pd_q == $past(wdata[obc_pkg::BANK_PD_B]) && src_sel_q == $past(wdata[obc_pkg::SRC_SEL_B])))
    else $error("power-down or source select not stored");
  a_out0_write: assert property (@(posedge clk) disable iff (rst)
    (ce && wr_en && addr == obc_pkg::ADDR_OUT0) |=> (out_q[0] == ($past(wdata) & obc_pkg::OUT_MASK)))
    else $error("output 0 config not stored");
  a_out1_write: assert property (@(posedge clk) disable iff (rst)
    (ce && wr_en && addr == obc_pkg::ADDR_OUT1) |=> (out_q[1] == ($past(wdata) & obc_pkg::OUT_MASK)))
    else $error("output 1 config not stored");
  a_pin_mode_on: assert property (@(posedge clk) disable iff (rst)
    (ce && !src_sel_q) |=> bank_c_drv_en == 2'h3)
    else $error("pin mode left an output powered down");
  a_c_style_map: assert property (@(posedge clk) disable iff (rst)
    (ce && src_sel_q && out_q[0][obc_pkg::STYLE_B]) |=> bank_c_drv_ecd[0])
    else $error("bank C style not applied");
  a_c_swing_map: assert property (@(posedge clk) disable iff (rst)
    (ce && src_sel_q && out_q[1][obc_pkg::SWING_LSB +: obc_pkg::SWING_W] == obc_pkg::SWING_750) |=>
      bank_c_drv_level[5:3] == obc_pkg::LVL_750)
    else $error("bank C swing not decoded");
  a_b_style_map: assert property (@(posedge clk) disable iff (rst)
    (ce && bank_b_output_driver_style[0]) |=> bank_b_drv_en_ecd[0])
    else $error("bank B style not applied");
  a_b_swing_map: assert property (@(posedge clk) disable iff (rst)
    (ce && bank_b_output_swing[1:0] == obc_pkg::SWING_500) |=> bank_b_drv_level[2:0] == obc_pkg::LVL_500)
    else $error("bank B swing not decoded");
  a_pin_div_commit: assert property (@(posedge clk) disable iff (rst)
    (ce && init_clk != init_q && !src_sel_q) |=> (act_div_q == $past(pin_div)))
    else $error("pin divider not committed on init toggle");
  a_pin_mode_style: assert property (@(posedge clk) disable iff (rst)
    (ce && !src_sel_q) |=> (bank_c_drv_ecd == 2'h0))
    else $error("pin mode left a non-default style");
  a_bank_off_map: assert property (@(posedge clk) disable iff (rst)
    ce |=> (bank_c_bank_off == $past(src_sel_q && bank_pd_q)))
    else $error("bank power-down not applied");
  a_c_pd_map: assert property (@(posedge clk) disable iff (rst)
    (ce && src_sel_q && (out_q[0][obc_pkg::OUT_PD_B] || bank_pd_q)) |=> !bank_c_drv_en[0])
    else $error("bank C output 0 not powered down");
  a_rsvd_read: assert property (@(posedge clk) disable iff (rst)
    (ce && rd_en && addr == obc_pkg::ADDR_RSV_A) |=> (rdata == obc_pkg::ZERO_BYTE))
    else $error("reserved address read not zero");

  c_init_commit: cover property (@(posedge clk) disable iff (rst) ce && init_clk != init_q && src_sel_q);
  c_reg_mode:    cover property (@(posedge clk) disable iff (rst) ce && wr_en && addr == obc_pkg::ADDR_PD && wdata[0]);
  c_bank_off:    cover property (@(posedge clk) disable iff (rst) bank_off_q);
  c_pin_commit:  cover property (@(posedge clk) disable iff (rst) ce && init_clk != init_q && !src_sel_q);
  c_rsvd_swing:  cover property (@(posedge clk) disable iff (rst)
    src_sel_q && out_q[0][obc_pkg::SWING_LSB +: obc_pkg::SWING_W] == obc_pkg::SWING_RSV);

endmodule

// ===== tb/obc_host_model.sv
// Host model that writes and reads the bank control registers one byte at a time
`timescale 1ns/100ps
module obc_host_model (
  input  wire logic       clk,
  output logic            wr_en,
  output logic            rd_en,
  output logic [7:0]      addr,
  output logic [7:0]      wdata
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end

  // Only the defined bits of each address may carry ones
  function automatic logic [7:0] legal(input logic [7:0] a);
    case (a)
      8'h20: return 8'h3F;
      8'h22: return 8'h81;
      8'h24, 8'h25: return 8'h87;
      default: return 8'h00;
    endcase
  endfunction

  // Request set after a falling edge and held across the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    d = d & legal(a);
    if (a == 8'h20 && d[5:0] == 6'h00) d[5:0] = 6'h01;
    wr_en = 1'b1;
    rd_en = 1'b0;
    addr = a;
    wdata = d;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    rd_en = 1'b1;
    wr_en = 1'b0;
    addr = a;
    wdata = ~wdata;
    @(posedge clk);
  endtask

  // Released lines never keep their last value
  task automatic idle;
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = ~addr;
    wdata = ~wdata;
  endtask
endmodule

// ===== tb/tb_output_bank_control_regs.sv
// Self-checking testbench for the output bank control registers
`timescale 1ns/100ps
module tb_output_bank_control_regs;
  logic        clk = 1'b0;
  logic        rst, ce, init_clk, wr_en, rd_en, boff, p, b;
  logic        rd_pend = 1'b0;
  logic [1:0]  pin_sel, bstyle, b_ecd, c_en, c_ecd, sw;
  logic [3:0]  bswing;
  logic [5:0]  b_lvl, div, c_lvl, dv, pv;
  logic [7:0]  addr, wdata, rdata, q[$];
  logic [31:0] seed;
  int          errors = 0;
  int          checks = 0;
  localparam logic [7:0] PDIV [4] = '{8'h0D, 8'h01, 8'h02, 8'h04};

  always #2 clk = ~clk;

  obc_regs #(.NUM_B(2)) u_dut (.clk(clk), .rst(rst), .ce(ce), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .init_clk(init_clk), .bank_c_pin_sel(pin_sel),
    .bank_b_output_driver_style(bstyle), .bank_b_output_swing(bswing), .bank_b_drv_en_ecd(b_ecd),
    .bank_b_drv_level(b_lvl), .bank_c_active_divider(div), .bank_c_bank_off(boff), .bank_c_drv_en(c_en),
    .bank_c_drv_ecd(c_ecd), .bank_c_drv_level(c_lvl));
  obc_host_model u_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // One-hot swing level, none for the reserved code
  function automatic logic [2:0] lvl(input logic [1:0] s);
    return (s == 2'h3) ? 3'h0 : 3'(1 << s);
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    u_host.rd(a);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Read data lands on the edge that takes the read and is checked at the next falling edge
  always @(posedge clk) rd_pend <= ce & rd_en & ~rst;
  always @(negedge clk) if (rd_pend) chk(rdata, q.pop_front());

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    init_clk = 1'b0;
    pin_sel = 2'h0;
    bstyle = 2'h0;
    bswing = 4'h0;
    seed = 32'h0E6114CC;
    pv = 6'h04;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) rd_exp(8'h20 + 8'(i), (i == 0) ? 8'h0D : 8'h00);
    u_host.idle();
    $display("done reset map");
    for (int i = 0; i < 4; i++) begin
      pin_sel = 2'(i);
      init_clk = ~init_clk;
      repeat (3) @(negedge clk);
      chk({2'h0, div}, PDIV[i]);
      chk({4'h0, c_en, c_ecd}, 8'h0C);
      chk({2'h0, c_lvl}, 8'h09);
    end
    $display("done pin mode");
    u_host.wr(8'h22, 8'h01);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      dv = seed[5:0] | 6'h20;
      u_host.wr(8'h20, {2'h0, dv});
      u_host.idle();
      repeat (3) @(negedge clk);
      chk({2'h0, div}, {2'h0, pv});
      init_clk = ~init_clk;
      repeat (3) @(negedge clk);
      chk({2'h0, div}, {2'h0, dv});
      pv = dv;
      rd_exp(8'h20, {2'h0, dv});
      u_host.idle();
    end
    $display("done divider commit");
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      p = seed[0];
      b = k[2];
      sw = 2'(k);
      u_host.wr(8'h24, {p, 4'h0, b, sw});
      u_host.wr(8'h25, {~p, 4'h0, ~b, ~sw});
      u_host.idle();
      repeat (3) @(negedge clk);
      chk({4'h0, c_en, c_ecd}, {4'h0, p, ~p, ~b, b});
      chk({2'h0, c_lvl}, {2'h0, lvl(~sw), lvl(sw)});
      rd_exp(8'h24, {p, 4'h0, b, sw});
      rd_exp(8'h25, {~p, 4'h0, ~b, ~sw});
      u_host.idle();
    end
    $display("done output config");
    u_host.wr(8'h22, 8'h81);
    u_host.idle();
    repeat (3) @(negedge clk);
    chk({5'h0, boff, c_en}, 8'h04);
    rd_exp(8'h22, 8'h81);
    u_host.wr(8'h22, 8'h00);
    u_host.idle();
    repeat (3) @(negedge clk);
    chk({5'h0, boff, c_en}, 8'h03);
    $display("done bank power-down");
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      bstyle = seed[1:0];
      bswing = 4'(k);
      @(negedge clk);
      chk({6'h0, b_ecd}, {6'h0, bstyle});
      chk({2'h0, b_lvl}, {2'h0, lvl(bswing[3:2]), lvl(bswing[1:0])});
    end
    ce = 1'b0;
    bstyle = ~bstyle;
    @(negedge clk);
    chk({6'h0, b_ecd}, {6'h0, ~bstyle});
    ce = 1'b1;
    $display("done bank b");
    end_sim();
  end
endmodule
